// ### core/fcd_clock_divider.v
// write-once memory timing clock divider with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "fcd_consts.vh"

// Overview of operation
// - bit 7 is a read-only loaded flag, cleared by reset, writes ignored.
// - bits 6..0 readable always, writable only once after each reset.
// - first write with byte lane 0 enabled after reset sets the loaded flag regardless of data.
// - erase and program are blocked until the loaded flag is set.
// - bit 6 selects bus clock or bus clock divided by eight.
// - selected input is divided by the 6-bit divisor field plus one.
// - each timing pulse lasts one bus clock cycle, once per derived clock period.
// - sequencer times operations as whole numbers of timing pulses.
module fcd_clock_divider (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire [3:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [3:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   output reg         memory_timing_clock_o,
   output reg         timing_pulse_o,
   output wire        prog_erase_enable_o
);

   reg                   divisor_loaded_flag_q;
   reg                   prescale_by_eight_sel_q;
   reg [`FCD_DIV_W-1:0]  divisor_q;
   reg                   aw_held_q;
   reg [3:0]             aw_addr_q;
   reg                   w_held_q;
   reg [31:0]            w_data_q;
   reg [3:0]             w_strb_q;
   reg [2:0]             pre_cnt_q;
   reg [`FCD_DIV_W-1:0]  div_cnt_q;
   reg [2:0]             pre_cnt_d;
   reg [`FCD_DIV_W-1:0]  div_cnt_d;
   reg                   clk_level_d;
   reg                   divisor_loaded_flag_d;
   reg                   prescale_by_eight_sel_d;
   reg [`FCD_DIV_W-1:0]  divisor_d;

   localparam [3:0] CTRL_ADDR = `FCD_CTRL_ADDR;

   // word decode shared by both channels, byte lane bits ignored
   function fcd_ctrl_hit;
      input [3:0] addr;
      begin
         fcd_ctrl_hit = addr[3:2] == CTRL_ADDR[3:2];
      end
   endfunction

   // level of the derived clock for a given divider phase: high for
   // the first half of the period, rounded up, so at divide by one
   // it stays high; ten bits cover the longest period of 512
   function fcd_clk_high;
      input                  pre_sel;
      input [2:0]            pre_val;
      input [`FCD_DIV_W-1:0] div_val;
      input [`FCD_DIV_W-1:0] div_max;
      reg   [9:0]            phase;
      reg   [9:0]            period;
      reg   [9:0]            half;
      begin
         if (pre_sel) begin
            phase  = {1'b0, div_val, pre_val};
            period = {{1'b0, div_max} + 7'h01, 3'h0};
         end else begin
            phase  = {4'h0, div_val};
            period = {3'h0, {1'b0, div_max} + 7'h01};
         end
         half         = (period + 10'h001) >> 1;
         fcd_clk_high = phase < half;
      end
   endfunction

   wire [7:0] ctrl_rd = {divisor_loaded_flag_q, prescale_by_eight_sel_q,
                         divisor_q};

   // address and data may arrive in either order; each is latched once
   assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held_q && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;

   wire       aw_now   = aw_held_q | s_axi_awvalid_i;
   wire       w_now    = w_held_q | s_axi_wvalid_i;
   wire [3:0] wa       = aw_held_q ? aw_addr_q : s_axi_awaddr_i;
   wire [31:0] wd      = w_held_q ? w_data_q : s_axi_wdata_i;
   wire [3:0] ws       = w_held_q ? w_strb_q : s_axi_wstrb_i;
   wire       wr_fire  = aw_now && w_now && !s_axi_bvalid_o;
   wire       wr_hit   = fcd_ctrl_hit(wa);
   // a write whose low lane is masked does not count as the write
   wire       ctrl_wr  = wr_fire && wr_hit && ws[0];

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         aw_held_q      <= 1'b0;
         aw_addr_q      <= 4'h0;
         w_held_q       <= 1'b0;
         w_data_q       <= 32'h0000_0000;
         w_strb_q       <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `FCD_RESP_OKAY;
      end else begin
         if (wr_fire) begin
            aw_held_q      <= 1'b0;
            w_held_q       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `FCD_RESP_OKAY : `FCD_RESP_SLVERR;
         end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
               aw_held_q <= 1'b1;
               aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
               w_held_q <= 1'b1;
               w_data_q <= s_axi_wdata_i;
               w_strb_q <= s_axi_wstrb_i;
            end
            if (s_axi_bvalid_o && s_axi_bready_i)
               s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // configuration next state: only the first counted write lands,
   // the flag itself is the lock, so no separate write-once bit
   always @* begin
      divisor_loaded_flag_d   = divisor_loaded_flag_q;
      prescale_by_eight_sel_d = prescale_by_eight_sel_q;
      divisor_d               = divisor_q;
      if (ctrl_wr && !divisor_loaded_flag_q) begin
         divisor_loaded_flag_d   = 1'b1;
         prescale_by_eight_sel_d = wd[`FCD_PRESCALE_BIT];
         divisor_d               = wd[`FCD_DIV_MSB:`FCD_DIV_LSB];
      end
   end

   // configuration register
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         {divisor_loaded_flag_q, prescale_by_eight_sel_q,
          divisor_q}             <= `FCD_CTRL_RESET;
      end else begin
         divisor_loaded_flag_q   <= divisor_loaded_flag_d;
         prescale_by_eight_sel_q <= prescale_by_eight_sel_d;
         divisor_q               <= divisor_d;
      end
   end

   // read channel
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= `FCD_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         if (fcd_ctrl_hit(s_axi_araddr_i)) begin
            s_axi_rdata_o <= {24'h000000, ctrl_rd};
            s_axi_rresp_o <= `FCD_RESP_OKAY;
         end else begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `FCD_RESP_SLVERR;
         end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // divider: prescale tick feeds a divide-by-(N+1) counter
   wire pre_tick = !prescale_by_eight_sel_q ||
                   (pre_cnt_q == `FCD_PRE_RATIO);
   wire div_wrap = pre_tick && (div_cnt_q == divisor_q);

   always @* begin
      pre_cnt_d = 3'h0;
      if (prescale_by_eight_sel_q)
         pre_cnt_d = pre_cnt_q + 3'h1;
      div_cnt_d = div_cnt_q;
      if (div_wrap)
         div_cnt_d = {`FCD_DIV_W{1'b0}};
      else if (pre_tick)
         div_cnt_d = div_cnt_q + {{(`FCD_DIV_W-1){1'b0}}, 1'b1};
      // judged on the next phase so the clock rises with the pulse
      clk_level_d = fcd_clk_high(prescale_by_eight_sel_q, pre_cnt_d,
                                 div_cnt_d, divisor_q);
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         pre_cnt_q             <= 3'h0;
         div_cnt_q             <= {`FCD_DIV_W{1'b0}};
         memory_timing_clock_o <= 1'b0;
         timing_pulse_o        <= 1'b0;
      end else begin
         pre_cnt_q             <= pre_cnt_d;
         div_cnt_q             <= div_cnt_d;
         // one bus-clock strobe per derived period, the unit the
         // sequencer counts; the clock level is secondary beside it
         timing_pulse_o        <= div_wrap;
         memory_timing_clock_o <= clk_level_d;
      end
   end

   // the sequencer relies on this gate, software must load first
   assign prog_erase_enable_o = divisor_loaded_flag_q;

endmodule // fcd_clock_divider
`default_nettype wire

// ### core/fcd_consts.vh
// register map, field layout and timing constants of the clock divider
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH

`define FCD_CTRL_ADDR      4'h0
`define FCD_LOADED_BIT     7
`define FCD_PRESCALE_BIT   6
`define FCD_DIV_MSB        5
`define FCD_DIV_LSB        0
`define FCD_DIV_W          6
`define FCD_CTRL_RESET     8'h00
`define FCD_PRE_RATIO      3'h7
`define FCD_RESP_OKAY      2'h0
`define FCD_RESP_SLVERR    2'h2

`endif

// ### tb/fcd_clock_divider_props.sv
// port assertions for the clock divider
`timescale 1ns/1ps
`default_nettype none
module fcd_props (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic        memory_timing_clock_o,
   input wire logic        timing_pulse_o,
   input wire logic        prog_erase_enable_o
);
   wire logic bv = s_axi_bvalid_o, br = s_axi_bready_i, tp = timing_pulse_o;
   wire logic rv = s_axi_rvalid_o, rr = s_axi_rready_i;
   wire logic en = prog_erase_enable_o;
   wire logic mc = memory_timing_clock_o;
   wire logic [31:0] rd = s_axi_rdata_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_BH: assert property (bv && !br |=> bv) else $error("bh");
   AST_BO: assert property (bv && br |=> !bv) else $error("bo");
   AST_RH: assert property (rv && !rr |=> rv && $stable(rd)) else $error("rh");
   AST_RO: assert property (rv && rr |=> !rv) else $error("ro");
   AST_RU: assert property (rv |-> rd[31:8] == 24'h0) else $error("ru");
   AST_FL: assert property (rv && rd[7] |-> en) else $error("fl");
   AST_ST: assert property (en |=> en) else $error("st");
   AST_P0: assert property (!en [*3] |-> tp) else $error("p0");
   AST_CK: assert property (tp |-> mc) else $error("ck");
   AST_LD: assert property ($rose(en) |-> $rose(bv)) else $error("ld");
endmodule // fcd_props
bind fcd_clock_divider fcd_props u_fcd_props (.*);
`default_nettype wire

// ### tb/fcd_seq_model.sv
// partner model: sequencer timing an operation in memory clock pulses
`timescale 1ns/1ps
`default_nettype none
module fcd_seq_model #(parameter int OP_PULSES = 4) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pulse_i,
   input  wire logic enable_i,
   input  wire logic start_i,
   output wire logic busy_o
);
   int left_q;
   assign busy_o = left_q != 0;
   // a start while the divider is unloaded is dropped, not queued
   always @(posedge clk_i) begin
      if (rst_i) left_q <= 0;
      else if (start_i && enable_i && !busy_o) left_q <= OP_PULSES;
      else if (busy_o && pulse_i) left_q <= left_q - 1;
   end
endmodule // fcd_seq_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the write-once clock divider
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        ref_clk_i = 0, rst_i = 1, go = 0, ta, tw, tr, td;
   logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
   logic [3:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 4'hF;
   logic [31:0] s_axi_wdata_i = 0, q;
   logic [1:0]  rs;
   wire logic [31:0] s_axi_rdata_o;
   wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   wire logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, busy;
   wire logic        s_axi_arready_o, s_axi_rvalid_o, memory_timing_clock_o;
   wire logic        timing_pulse_o, prog_erase_enable_o;
   int          checks = 0, num_errors = 0;
   fcd_clock_divider u_fcd_clock_divider (.*);
   fcd_seq_model u_fcd_seq_model (.clk_i(ref_clk_i), .rst_i(rst_i),
      .pulse_i(timing_pulse_o), .enable_i(prog_erase_enable_o),
      .start_i(go), .busy_o(busy));
   task automatic chk(input string s, input logic [31:0] e, g);
      checks++;
      if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
      if (g !== e) num_errors++;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // readies sampled at the falling edge, released after the taking edge
   task automatic bus(input bit rd, input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      if (rd) {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
      else {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wvalid_i} <= {a, 2'h3};
      if (!rd) {s_axi_wdata_i, s_axi_bready_i} <= {24'h0, d, 1'h1};
      repeat (20) begin
         @(negedge ref_clk_i);
         {ta, tw, tr} = {s_axi_awready_o, s_axi_wready_o, s_axi_arready_o};
         td = rd ? s_axi_rvalid_o : s_axi_bvalid_o;
         {rs, q} = rd ? {s_axi_rresp_o, s_axi_rdata_o} : {s_axi_bresp_o, 32'h0};
         @(posedge ref_clk_i);
         if (ta) s_axi_awvalid_i <= 0;
         if (tw) s_axi_wvalid_i <= 0;
         if (tr) s_axi_arvalid_i <= 0;
         if (td) {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
         if (td) return;
      end
      chk("bus", 1, 0);
      test_done;
   endtask
   task automatic per(input int e);
      int k;
      @(negedge ref_clk_i);
      for (k = 0; k < 999 && timing_pulse_o !== 1; k++) @(negedge ref_clk_i);
      chk("pulse", 1, timing_pulse_o);
      @(negedge ref_clk_i);
      for (k = 1; k < 999 && timing_pulse_o !== 1; k++) @(negedge ref_clk_i);
      chk("period", e, k);
      chk("memory_timing_clock", 1, memory_timing_clock_o);
      if (k == 999) test_done;
   endtask
   task automatic kick;
      @(posedge ref_clk_i) go <= 1;
      @(posedge ref_clk_i) go <= 0;
   endtask
   task automatic sc_fresh;
      @(posedge ref_clk_i) rst_i <= 1;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 0;
      bus(1, 4'h0, 8'h00);
      chk("ctrl", 32'h0, q);
      per(1);
      chk("enable", 0, prog_erase_enable_o);
      @(posedge ref_clk_i) s_axi_wstrb_i <= 4'hE;
      bus(0, 4'h0, 8'h63);
      @(posedge ref_clk_i) s_axi_wstrb_i <= 4'hF;
      bus(1, 4'h0, 8'h00);
      chk("masked", 32'h0, q);
      kick;
      repeat (3) @(negedge ref_clk_i);
      chk("blocked", 0, busy);
   endtask
   task automatic sc_load;
      bus(0, 4'h0, 8'h63);
      bus(1, 4'h0, 8'h00);
      chk("ctrl", 32'hE3, q);
      per(288);
      repeat (200) @(negedge ref_clk_i);
      chk("memory_timing_clock", 0, memory_timing_clock_o);
      chk("enable", 1, prog_erase_enable_o);
      kick;
      repeat (864) @(negedge ref_clk_i);
      chk("busy", 1, busy);
      repeat (290) @(negedge ref_clk_i);
      chk("done", 0, busy);
   endtask
   task automatic sc_lock;
      bus(0, 4'h0, 8'h05);
      chk("resp", 0, rs);
      bus(1, 4'h0, 8'h00);
      chk("lock", 32'hE3, q);
      per(288);
      bus(1, 4'h4, 8'h00);
      chk("unmap", 2, rs);
      chk("unmap data", 0, q);
      bus(0, 4'h4, 8'h00);
      chk("unmap wr", 2, rs);
   endtask
   task automatic sc_div;
      bus(0, 4'h0, 8'h81);
      bus(1, 4'h0, 8'h00);
      chk("ctrl", 32'h81, q);
      per(2);
   endtask
   initial forever #10 ref_clk_i = ~ref_clk_i;
   initial begin
      sc_fresh;
      sc_load;
      sc_lock;
      sc_fresh;
      sc_div;
      test_done;
   end
endmodule // tb
`default_nettype wire
